// [hw/pwr_path_pkg.sv]
// Shared constants and types of the bus power path control block.
// Assumes a single 125 MHz system clock and a synchronous active-low reset.
package pwr_path_pkg;

  // Attach states reported by the Type-C state machine on the same clock.
  typedef enum logic [2:0] {
    ST_UNATTACHED,
    ST_ATTACHED_SRC,
    ST_ATTACHED_SNK,
    ST_UNORIENTED_DBG_SRC,
    ST_DBG_ACC_SNK,
    ST_ERROR_RECOVERY,
    ST_OTHER
  } attach_state_t;

  localparam int          CLK_HZ          = 125_000_000;
  localparam int          MS_PER_S        = 1_000;
  localparam int          CYCLES_PER_MS   = CLK_HZ / MS_PER_S;
  localparam int          TIME_W          = 10;

  // Plug supply discharge after sink detach.
  localparam logic [9:0]  PLUG_DISCH_MS   = 10'h0FA;
  // Monitoring blanking after a profile voltage change.
  localparam logic [9:0]  BLANK_MS_RST    = 10'h12C;
  // Bus discharge duration used when start-up settings are absent.
  localparam logic [9:0]  BUS_DISCH_MS_RST = 10'h0C8;

  // Plug supply undervoltage level select: 0 picks 4.65 V, 1 picks 2.65 V.
  localparam logic        PLUG_UVLO_HIGH  = 1'h0;
  localparam logic        PLUG_UVLO_LOW   = 1'h1;

  // Positions of the analog comparator inputs in the synchroniser vector.
  localparam int          PIN_BUS_SAFE0V  = 0;
  localparam int          PIN_BUS_WINDOW  = 1;
  localparam int          PIN_BUS_UVLO    = 2;
  localparam int          PIN_SUP_UVLO    = 3;
  localparam int          PIN_SUP_OVLO    = 4;
  localparam int          PIN_PLUG_UVLO   = 5;
  localparam int          PIN_RA_CC1      = 6;
  localparam int          PIN_RA_CC2      = 7;
  localparam int          PIN_COUNT       = 8;

endpackage : pwr_path_pkg

// [hw/ms_timer.sv]
// Millisecond down-counter: loaded by a start pulse, busy until it expires.
// Assumes a one-cycle millisecond tick on the same clock.
`timescale 1ns/1ps
`default_nettype none
module ms_timer #(
  parameter int W = 10
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rst_n, // synchronous reset, active low
  input  wire logic         start, // load pulse
  input  wire logic [W-1:0] len,   // duration in milliseconds
  input  wire logic         tick,  // millisecond enable
  output logic              busy   // high while counting
);

  logic [W-1:0] count_ff;

  // A start in the tick cycle wins, so a retrigger is never shortened.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      count_ff <= '0;
    else if (start)
      count_ff <= len;
    else if (tick && count_ff != '0)
      count_ff <= count_ff - W'(1);
  end

  assign busy = (count_ff != '0);

endmodule : ms_timer
`default_nettype wire

// [hw/pwr_path_ctrl.sv]
// Bus power path and plug supply control of a Type-C port controller.
// Assumes the attach state machine runs on SYS_CLK; comparators are pins.
//
// Overview of operation
// (R1) Bus discharge starts on detach or error recovery entry, any role.
// (R2) Bus discharge on after start-up; only start-up settings turn it off.
// (R3) Discharge duration loads from start-up; software may overwrite it.
// (R4) Source enable driven low only in source states with all checks valid.
// (R5) Source enable released otherwise or when the bus check fails.
// (R6) Supply checks qualify only the source path, never the sink path.
// (R7) Supply check enables load from start-up and software may change them.
// (R8) Once source path is on, supply checks stop; bus monitoring remains.
// (R9) Source path stays on while attached and bus condition stays valid.
// (R10) Bus check uses the window, or the undervoltage level when disabled.
// (R11) Window or undervoltage choice loads at start-up; software may change.
// (R12) Source attach allowed only while bus is at safe zero volts.
// (R13) Sink enable driven low only in sink states with bus valid.
// (R14) Sink enable released otherwise or when bus is invalid.
// (R15) Plug supply only onto unwired pin, when all conditions hold.
// (R16) Plug supply never applied in the sink power role.
// (R17) Plug undervoltage level defaults high; software selects low level.
// (R18) Source role plug discharge lasts 250 ms after sink detach if enabled.
// (R19) Software plug supply controls are honoured and state is visible.
// (R20) Profile change blanks bus monitoring; discharge if going lower.
// (R21) Bus loss after attach drops path: error recovery or unattached.
// (R22) Each enable is open drain: low drive plus an output enable.
`timescale 1ns/1ps
`default_nettype none
module pwr_path_ctrl #(
  parameter int MS_DIV   = pwr_path_pkg::CYCLES_PER_MS, // cycles per ms
  parameter int BLANK_MS = int'(pwr_path_pkg::BLANK_MS_RST) // blanking
) (
  input  wire logic       SYS_CLK,           // 125 MHz clock
  input  wire logic       NRST,              // sync reset, active low
  input  wire logic [2:0] ATTACH_STATE,      // attach_state_status
  input  wire logic       CC_ORIENT,         // 0: CC1 wired, 1: CC2 wired
  input  wire logic       ROLE_SRC,          // source role configured
  input  wire logic       ROLE_DRP,          // dual role configured
  input  wire logic [pwr_path_pkg::PIN_COUNT-1:0] ANALOG_IN, // comparator pins
  input  wire logic       PROFILE_CHANGE,    // pulse: new bus voltage
  input  wire logic       PROFILE_LOWER,     // new voltage below old
  input  wire logic       NVM_DISCH_EN,      // start-up discharge enable
  input  wire logic [9:0] NVM_DISCH_MS,      // start-up discharge time
  input  wire logic       NVM_SUP_UVLO_EN,   // start-up supply UV check
  input  wire logic       NVM_SUP_OVLO_EN,   // start-up supply OV check
  input  wire logic       NVM_WINDOW_EN,     // start-up window check
  input  wire logic       NVM_PLUG_DISCH_EN, // start-up plug discharge
  input  wire logic       SW_WR,             // pulse: load software bits
  input  wire logic [9:0] SW_DISCH_MS,       // discharge time
  input  wire logic       SW_SUP_UVLO_EN,    // supply UV check enable
  input  wire logic       SW_SUP_OVLO_EN,    // supply OV check enable
  input  wire logic       SW_WINDOW_EN,      // window check enable
  input  wire logic       SW_PLUG_DISCH_EN,  // plug discharge enable
  input  wire logic       SW_PLUG_SW_EN,     // plug supply switches on
  input  wire logic       SW_PLUG_UVLO_LOW,  // select 2.65 V level
  output logic            SRC_PATH_EN_N_O,   // source enable drive level
  output logic            SRC_PATH_EN_N_OE,  // source enable drive on
  output logic            SNK_PATH_EN_N_O,   // sink enable drive level
  output logic            SNK_PATH_EN_N_OE,  // sink enable drive on
  output logic            BUS_DISCHARGE,     // bus discharge path on
  output logic            PLUG_DISCHARGE,    // plug discharge on CC pins
  output logic            PLUG_SUPPLY_CC1,   // plug supply onto CC1
  output logic            PLUG_SUPPLY_CC2,   // plug supply onto CC2
  output logic            PLUG_UVLO_LOW_SEL, // plug UV level select
  output logic            SRC_ATTACH_OK,     // bus at safe zero volts
  output logic            ERR_RECOVERY_REQ,  // pulse: source bus lost
  output logic            UNATTACH_REQ,      // pulse: sink bus lost
  output logic            BUS_MON_BLANKED,   // monitoring suspended
  output logic [9:0]      DISCH_MS_Q,        // current discharge time
  output logic            PLUG_SW_EN_Q       // current plug switch enable
);

  localparam int PIN_N = pwr_path_pkg::PIN_COUNT;

  typedef enum logic [1:0] {SRC_OFF, SRC_ON} src_path_t;

  // Two-stage synchroniser for every comparator pin.
  logic [PIN_N-1:0] meta_ff;
  logic [PIN_N-1:0] pin_q_ff;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_N; gi++)
    begin : g_sync
      always_ff @(posedge SYS_CLK)
      begin
        if (!NRST)
        begin
          meta_ff[gi]  <= 1'h0;
          pin_q_ff[gi] <= 1'h0;
        end
        else
        begin
          meta_ff[gi]  <= ANALOG_IN[gi];
          pin_q_ff[gi] <= meta_ff[gi];
        end
      end
    end
  endgenerate

  // Configuration: start-up values are taken during reset.
  logic       disch_en_ff;
  logic [9:0] disch_ms_ff;
  logic       sup_uvlo_en_ff;
  logic       sup_ovlo_en_ff;
  logic       window_en_ff;
  logic       plug_disch_en_ff;
  logic       plug_sw_en_ff;
  logic       plug_uvlo_low_ff;

  // The discharge enable has no software path on purpose.
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      disch_en_ff <= NVM_DISCH_EN; // [R2]
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      disch_ms_ff      <= NVM_DISCH_MS;         // [R3]
      sup_uvlo_en_ff   <= NVM_SUP_UVLO_EN;      // [R7]
      sup_ovlo_en_ff   <= NVM_SUP_OVLO_EN;
      window_en_ff     <= NVM_WINDOW_EN;        // [R11]
      plug_disch_en_ff <= NVM_PLUG_DISCH_EN;    // [R18]
      plug_sw_en_ff    <= 1'h0;
      plug_uvlo_low_ff <= pwr_path_pkg::PLUG_UVLO_HIGH; // [R17]
    end
    else if (SW_WR)
    begin
      disch_ms_ff      <= SW_DISCH_MS;          // [R3]
      sup_uvlo_en_ff   <= SW_SUP_UVLO_EN;       // [R7]
      sup_ovlo_en_ff   <= SW_SUP_OVLO_EN;
      window_en_ff     <= SW_WINDOW_EN;         // [R11]
      plug_disch_en_ff <= SW_PLUG_DISCH_EN;     // [R18]
      plug_sw_en_ff    <= SW_PLUG_SW_EN;        // [R19]
      plug_uvlo_low_ff <= SW_PLUG_UVLO_LOW;     // [R17]
    end
  end

  // Millisecond enable shared by all timers.
  logic [$clog2(MS_DIV+1)-1:0] div_ff;
  logic                        ms_tick;

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST || ms_tick)
      div_ff <= '0;
    else
      div_ff <= div_ff + 1'b1;
  end

  assign ms_tick = (div_ff == ($clog2(MS_DIV+1))'(MS_DIV - 1));

  // Attach state decode and edge detection.
  pwr_path_pkg::attach_state_t st;
  pwr_path_pkg::attach_state_t st_prev_ff;
  logic src_state;
  logic snk_state;
  logic src_prev;
  logic attached_prev;
  logic detach_evt;
  logic err_entry_evt;

  assign st = pwr_path_pkg::attach_state_t'(ATTACH_STATE);

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      st_prev_ff <= pwr_path_pkg::ST_UNATTACHED;
    else
      st_prev_ff <= st;
  end

  assign src_state = (st == pwr_path_pkg::ST_ATTACHED_SRC) ||
                     (st == pwr_path_pkg::ST_UNORIENTED_DBG_SRC);
  assign snk_state = (st == pwr_path_pkg::ST_ATTACHED_SNK) ||
                     (st == pwr_path_pkg::ST_DBG_ACC_SNK);
  assign src_prev  = (st_prev_ff == pwr_path_pkg::ST_ATTACHED_SRC) ||
                     (st_prev_ff == pwr_path_pkg::ST_UNORIENTED_DBG_SRC);
  assign attached_prev = src_prev ||
                     (st_prev_ff == pwr_path_pkg::ST_ATTACHED_SNK) ||
                     (st_prev_ff == pwr_path_pkg::ST_DBG_ACC_SNK);
  assign detach_evt    = attached_prev &&
                         (st == pwr_path_pkg::ST_UNATTACHED);
  assign err_entry_evt = (st == pwr_path_pkg::ST_ERROR_RECOVERY) &&
                         (st_prev_ff != pwr_path_pkg::ST_ERROR_RECOVERY);

  // Profile change blanking window.
  logic blank_busy;
  logic lower_ff;

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      lower_ff <= 1'h0;
    else if (PROFILE_CHANGE)
      lower_ff <= PROFILE_LOWER;
  end

  ms_timer #(.W(pwr_path_pkg::TIME_W)) u_blank (
    .clk   (SYS_CLK),
    .rst_n (NRST),
    .start (PROFILE_CHANGE),
    .len   (pwr_path_pkg::TIME_W'(BLANK_MS)),
    .tick  (ms_tick),
    .busy  (blank_busy)
  );

  // Bus and supply qualification.
  logic bus_ok;
  logic supply_ok;

  // While blanked the bus is treated as valid, since it is moving on purpose.
  assign bus_ok = blank_busy ||                                   // [R20]
                  (window_en_ff ? pin_q_ff[pwr_path_pkg::PIN_BUS_WINDOW]
                                : pin_q_ff[pwr_path_pkg::PIN_BUS_UVLO]); // [R10]
  assign supply_ok =
    (!sup_uvlo_en_ff || pin_q_ff[pwr_path_pkg::PIN_SUP_UVLO]) &&
    (!sup_ovlo_en_ff || !pin_q_ff[pwr_path_pkg::PIN_SUP_OVLO]);

  // Source path: supply checks gate only the turn-on.
  src_path_t src_ff;
  src_path_t nxt_src;

  always_comb
  begin
    nxt_src = src_ff;
    case (src_ff)
      SRC_OFF:
        if (src_state && bus_ok && supply_ok)                  // [R4] [R6]
          nxt_src = SRC_ON;
      SRC_ON:
        if (!src_state || !bus_ok)                             // [R5] [R9]
          nxt_src = SRC_OFF;                                   // [R8]
      default:
        nxt_src = SRC_OFF;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      src_ff <= SRC_OFF;
    else
      src_ff <= nxt_src;
  end

  // Sink path ignores the supply checks entirely.
  logic snk_on_ff;

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      snk_on_ff <= 1'h0;
    else
      snk_on_ff <= snk_state && bus_ok;                        // [R13] [R14]
  end

  // Open-drain enables: the drive level is always low.
  assign SRC_PATH_EN_N_O  = 1'h0;                               // [R22]
  assign SRC_PATH_EN_N_OE = (src_ff == SRC_ON);
  assign SNK_PATH_EN_N_O  = 1'h0;
  assign SNK_PATH_EN_N_OE = snk_on_ff;

  // Loss of the bus after attach.
  logic err_req_ff;
  logic unatt_req_ff;

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      err_req_ff   <= 1'h0;
      unatt_req_ff <= 1'h0;
    end
    else
    begin
      err_req_ff   <= (src_ff == SRC_ON) && src_state && !bus_ok; // [R21]
      unatt_req_ff <= snk_on_ff && snk_state && !bus_ok;          // [R21]
    end
  end

  assign ERR_RECOVERY_REQ = err_req_ff;
  assign UNATTACH_REQ     = unatt_req_ff;

  // Bus discharge sequencing.
  logic disch_start;
  logic disch_busy;
  logic bus_disch_ff;

  assign disch_start = disch_en_ff && (detach_evt || err_entry_evt); // [R1]

  ms_timer #(.W(pwr_path_pkg::TIME_W)) u_bus_disch (
    .clk   (SYS_CLK),
    .rst_n (NRST),
    .start (disch_start),
    .len   (disch_ms_ff),                                      // [R3]
    .tick  (ms_tick),
    .busy  (disch_busy)
  );

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      bus_disch_ff <= 1'h0;
    else
      bus_disch_ff <= disch_busy ||
                      (disch_en_ff && blank_busy && lower_ff); // [R20]
  end

  assign BUS_DISCHARGE = bus_disch_ff;

  // Plug supply discharge after a sink leaves a source port.
  logic plug_disch_start;
  logic plug_disch_busy;
  logic plug_disch_ff;

  assign plug_disch_start = plug_disch_en_ff && src_prev && !src_state &&
                            ROLE_SRC;                          // [R18]

  ms_timer #(.W(pwr_path_pkg::TIME_W)) u_plug_disch (
    .clk   (SYS_CLK),
    .rst_n (NRST),
    .start (plug_disch_start),
    .len   (pwr_path_pkg::PLUG_DISCH_MS),
    .tick  (ms_tick),
    .busy  (plug_disch_busy)
  );

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      plug_disch_ff <= 1'h0;
    else
      plug_disch_ff <= plug_disch_busy;
  end

  assign PLUG_DISCHARGE = plug_disch_ff;

  // Plug supply switching onto the unwired CC pin.
  logic plug_ok;
  logic plug_cc1_ff;
  logic plug_cc2_ff;

  assign plug_ok = (ROLE_SRC || ROLE_DRP) && plug_sw_en_ff && src_state &&
                   !snk_state && pin_q_ff[pwr_path_pkg::PIN_PLUG_UVLO]; // [R15]

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      plug_cc1_ff <= 1'h0;
      plug_cc2_ff <= 1'h0;
    end
    else
    begin
      plug_cc1_ff <= plug_ok && CC_ORIENT &&
                     pin_q_ff[pwr_path_pkg::PIN_RA_CC1];       // [R15] [R16]
      plug_cc2_ff <= plug_ok && !CC_ORIENT &&
                     pin_q_ff[pwr_path_pkg::PIN_RA_CC2];       // [R15] [R16]
    end
  end

  assign PLUG_SUPPLY_CC1   = plug_cc1_ff;
  assign PLUG_SUPPLY_CC2   = plug_cc2_ff;
  assign PLUG_UVLO_LOW_SEL = plug_uvlo_low_ff;                 // [R17]
  assign PLUG_SW_EN_Q      = plug_sw_en_ff;                    // [R19]
  assign DISCH_MS_Q        = disch_ms_ff;
  assign SRC_ATTACH_OK     = pin_q_ff[pwr_path_pkg::PIN_BUS_SAFE0V]; // [R12]
  assign BUS_MON_BLANKED   = blank_busy;

  // Checks.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);

  sequence src_turn_on_s;
    (src_ff == SRC_OFF) && src_state && bus_ok && supply_ok;
  endsequence

  sequence src_bus_lost_s;
    (src_ff == SRC_ON) && src_state && !bus_ok;
  endsequence

  src_drive_a: assert property ($rose(SRC_PATH_EN_N_OE) |->  // [R4]
    $past(src_state && bus_ok && supply_ok))
    else $error("source enable driven without valid conditions");

  src_release_a: assert property (!src_state |=>             // [R5]
    !SRC_PATH_EN_N_OE)
    else $error("source enable held outside source states");

  src_turn_on_a: assert property (src_turn_on_s |=>          // [R4]
    SRC_PATH_EN_N_OE)
    else $error("source enable not driven when conditions held");

  supply_ignored_a: assert property (SRC_PATH_EN_N_OE &&    // [R8]
    src_state && bus_ok |=> SRC_PATH_EN_N_OE)
    else $error("source enable dropped while bus valid");

  err_request_a: assert property (src_bus_lost_s |=>         // [R21]
    ERR_RECOVERY_REQ && !SRC_PATH_EN_N_OE)
    else $error("bus loss on source did not request recovery");

  snk_drive_a: assert property (SNK_PATH_EN_N_OE |->         // [R13]
    $past(snk_state && bus_ok))
    else $error("sink enable driven without valid conditions");

  snk_release_a: assert property (!bus_ok |=>                // [R14]
    !SNK_PATH_EN_N_OE)
    else $error("sink enable held with bus invalid");

  bus_disch_a: assert property (disch_start &&               // [R1]
    disch_ms_ff != '0 |=> ##1 BUS_DISCHARGE)
    else $error("bus discharge did not start");

  plug_sink_a: assert property (snk_state ||                 // [R16]
    (!ROLE_SRC && !ROLE_DRP) |=> !PLUG_SUPPLY_CC1 && !PLUG_SUPPLY_CC2)
    else $error("plug supply applied in sink role");

  plug_one_pin_a: assert property (!(PLUG_SUPPLY_CC1 &&      // [R15]
    PLUG_SUPPLY_CC2))
    else $error("plug supply on both CC pins");

  plug_disch_a: assert property (plug_disch_start |=> ##1    // [R18]
    PLUG_DISCHARGE [*8])
    else $error("plug discharge not held after detach");

endmodule : pwr_path_ctrl
`default_nettype wire

// [sim/bus_switch_model.sv]
// Far side of the power path: bus switches, bus charge and plug supply.
// Assumes the bench commands faults; the bus moves one step per clock.
`timescale 1ns/1ps
`default_nettype none
module bus_switch_model (
  input  wire logic       clk,    // system clock
  input  wire logic       src_on, // source switch closed by the pin
  input  wire logic       ext_on, // far source feeding the bus
  input  wire logic       dis_on, // bus discharge path on
  input  wire logic       sag,    // bus below window, above UVLO
  input  wire logic       fault,  // bus collapsed
  input  wire logic [5:3] aux,    // plug UV, supply OV, supply UV
  input  wire logic [7:6] ra,     // Ra seen on CC2 and CC1
  output logic      [7:0] pins    // comparator levels
);
  int lvl = 0;

  // A released bus keeps its charge; only the discharge path drains it,
  // so a design that forgets the discharge leaves the bus up.
  always @(posedge clk)
  begin
    if ((src_on || ext_on) && lvl < 8)
    begin
      lvl <= lvl + 1;
    end
    else if (!(src_on || ext_on) && dis_on && lvl > 0)
    begin
      lvl <= lvl - 1;
    end
  end

  assign pins = {ra, aux, lvl >= 4 && !fault,
                 lvl >= 7 && !sag && !fault, lvl == 0};
endmodule : bus_switch_model
`default_nettype wire

// [sim/tb_top.sv]
// Self-checking bench of the power path control with a far-side model.
// Assumes the package and design are compiled first; 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int MS    = 4;
  localparam int BLANK = 6;
  logic       SYS_CLK = 1'b0, NRST = 1'b0;
  logic [2:0] ATTACH_STATE = 3'h0;
  logic       CC_ORIENT = 1'b0, ROLE_SRC = 1'b1, ROLE_DRP = 1'b0;
  logic       PROFILE_CHANGE = 1'b0, PROFILE_LOWER = 1'b0, SW_WR = 1'b0;
  logic       NVM_DISCH_EN = 1'b1, NVM_SUP_UVLO_EN = 1'b1;
  logic       NVM_SUP_OVLO_EN = 1'b1, NVM_WINDOW_EN = 1'b1;
  logic       NVM_PLUG_DISCH_EN = 1'b1, SW_SUP_UVLO_EN = 1'b1;
  logic       SW_SUP_OVLO_EN = 1'b1, SW_WINDOW_EN = 1'b0;
  logic       SW_PLUG_DISCH_EN = 1'b0, SW_PLUG_SW_EN = 1'b1;
  logic       SW_PLUG_UVLO_LOW = 1'b1;
  logic [9:0] NVM_DISCH_MS = 10'h003, SW_DISCH_MS = 10'h001, dms;
  logic       ext_on = 1'b0, sag = 1'b0, fault = 1'b0, ori, flip;
  logic [2:0] aux = 3'h0;
  logic [1:0] ra = 2'h0;
  logic [7:0] ANALOG_IN;
  logic       SRC_PATH_EN_N_O, SRC_PATH_EN_N_OE, SNK_PATH_EN_N_O;
  logic       SNK_PATH_EN_N_OE, BUS_DISCHARGE, PLUG_DISCHARGE;
  logic       PLUG_SUPPLY_CC1, PLUG_SUPPLY_CC2, PLUG_UVLO_LOW_SEL;
  logic       SRC_ATTACH_OK, ERR_RECOVERY_REQ, UNATTACH_REQ;
  logic       BUS_MON_BLANKED, PLUG_SW_EN_Q;
  logic [9:0] DISCH_MS_Q;
  logic [47:0] notes[$];
  logic [47:0] note;
  int          n_errors = 0, num_checks = 0;
  wire logic [23:0] obs;

  assign obs = {DISCH_MS_Q, SRC_PATH_EN_N_O, SNK_PATH_EN_N_O,
                SRC_PATH_EN_N_OE, SNK_PATH_EN_N_OE, BUS_DISCHARGE,
                PLUG_DISCHARGE, PLUG_SUPPLY_CC1, PLUG_SUPPLY_CC2,
                PLUG_UVLO_LOW_SEL, SRC_ATTACH_OK, ERR_RECOVERY_REQ,
                UNATTACH_REQ, BUS_MON_BLANKED, PLUG_SW_EN_Q};

  pwr_path_ctrl #(.MS_DIV(MS), .BLANK_MS(BLANK)) pwr_path_ctrl_i (
    .SYS_CLK, .NRST, .ATTACH_STATE, .CC_ORIENT, .ROLE_SRC, .ROLE_DRP,
    .ANALOG_IN, .PROFILE_CHANGE, .PROFILE_LOWER, .NVM_DISCH_EN,
    .NVM_DISCH_MS, .NVM_SUP_UVLO_EN, .NVM_SUP_OVLO_EN, .NVM_WINDOW_EN,
    .NVM_PLUG_DISCH_EN, .SW_WR, .SW_DISCH_MS, .SW_SUP_UVLO_EN,
    .SW_SUP_OVLO_EN, .SW_WINDOW_EN, .SW_PLUG_DISCH_EN, .SW_PLUG_SW_EN,
    .SW_PLUG_UVLO_LOW, .SRC_PATH_EN_N_O, .SRC_PATH_EN_N_OE,
    .SNK_PATH_EN_N_O, .SNK_PATH_EN_N_OE, .BUS_DISCHARGE, .PLUG_DISCHARGE,
    .PLUG_SUPPLY_CC1, .PLUG_SUPPLY_CC2, .PLUG_UVLO_LOW_SEL, .SRC_ATTACH_OK,
    .ERR_RECOVERY_REQ, .UNATTACH_REQ, .BUS_MON_BLANKED, .DISCH_MS_Q,
    .PLUG_SW_EN_Q
  );

  bus_switch_model bus_switch_model_i (
    .clk(SYS_CLK), .src_on(SRC_PATH_EN_N_OE && !SRC_PATH_EN_N_O),
    .ext_on, .dis_on(BUS_DISCHARGE), .sag, .fault, .aux, .ra,
    .pins(ANALOG_IN)
  );

  initial
  begin
    forever #4 SYS_CLK = ~SYS_CLK;
  end

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_errors++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
    end
  endtask : check

  // Notes are pushed on a clock edge and judged at the following falling
  // edge, so each one sees the outputs that this edge produced.
  task automatic expect_obs(input logic [23:0] m, input logic [23:0] v);
    notes.push_back({m, v});
    @(posedge SYS_CLK);
  endtask : expect_obs

  always @(negedge SYS_CLK)
  begin
    if (notes.size() > 0)
    begin
      note = notes.pop_front();
      check(obs & note[47:24], note[23:0]);
    end
  end

  task automatic wait_for(input int idx, input logic v, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    while (obs[idx] !== v && n < lim);
    if (obs[idx] !== v)
    begin
      n_errors++;
      $display("unexpected at %0t: wait ran out on bit %0d", $time, idx);
      tally_and_finish();
    end
  endtask : wait_for

  task automatic measure(input int idx, input int lo, input int hi);
    int n;
    wait_for(idx, 1'b1, 8);
    n = 0;
    while (obs[idx] === 1'b1 && n <= hi)
    begin
      @(posedge SYS_CLK);
      #1;
      n++;
    end
    check({23'h00_0000, n >= lo && n <= hi}, 24'h00_0001);
  endtask : measure

  initial
  begin
    void'($urandom(32'h5715));
    repeat (8) @(posedge SYS_CLK);
    NRST <= 1'b1;
    @(posedge SYS_CLK);
    expect_obs(24'hFF_FC21, 24'h00_C000);
    repeat (3) @(posedge SYS_CLK);
    expect_obs(24'h00_0010, 24'h00_0010);
    ATTACH_STATE <= pwr_path_pkg::ST_ATTACHED_SRC;
    PROFILE_CHANGE <= 1'b1;
    @(posedge SYS_CLK);
    PROFILE_CHANGE <= 1'b0;
    repeat (4) @(posedge SYS_CLK);
    expect_obs(24'h00_3802, 24'h00_0002);
    aux <= 3'b001;
    wait_for(11, 1'b1, 8);
    repeat (24) @(posedge SYS_CLK);
    aux <= 3'b000;
    repeat (4) @(posedge SYS_CLK);
    expect_obs(24'h00_0802, 24'h00_0800);
    sag <= 1'b1;
    wait_for(11, 1'b0, 6);
    expect_obs(24'h00_0808, 24'h00_0008);
    ATTACH_STATE <= pwr_path_pkg::ST_ERROR_RECOVERY;
    fork
      measure(9, 2 * MS, 3 * MS + 1);
      measure(8, 249 * MS, 250 * MS + 1);
    join
    @(posedge SYS_CLK);
    ATTACH_STATE <= pwr_path_pkg::ST_UNATTACHED;
    dms = 10'($urandom_range(6, 1));
    SW_DISCH_MS <= dms;
    SW_WR <= 1'b1;
    @(posedge SYS_CLK);
    SW_WR <= 1'b0;
    expect_obs(24'hFF_C021, {dms, 14'h0021});
    ROLE_SRC <= 1'b0;
    ATTACH_STATE <= pwr_path_pkg::ST_ATTACHED_SNK;
    ext_on <= 1'b1;
    aux <= 3'b110;
    ra <= 2'b11;
    wait_for(10, 1'b1, 20);
    expect_obs(24'h00_38D0, 24'h00_0000);
    fault <= 1'b1;
    wait_for(10, 1'b0, 6);
    expect_obs(24'h00_0404, 24'h00_0004);
    ATTACH_STATE <= pwr_path_pkg::ST_UNATTACHED;
    ext_on <= 1'b0;
    measure(9, (int'(dms) - 1) * MS, int'(dms) * MS + 1);
    expect_obs(24'h00_0100, 24'h00_0000);
    fault <= 1'b0;
    ROLE_DRP <= 1'b1;
    ATTACH_STATE <= pwr_path_pkg::ST_ATTACHED_SRC;
    flip = 1'($urandom_range(1, 0));
    for (int k = 0; k < 2; k++)
    begin
      ori = (k == 1) ^ flip;
      CC_ORIENT <= ori;
      ra <= ori ? 2'b01 : 2'b10;
      aux <= 3'b100;
      repeat (4) @(posedge SYS_CLK);
      expect_obs(24'h00_00C0, {16'h0000, ori, !ori, 6'h00});
      aux <= 3'b000;
      repeat (4) @(posedge SYS_CLK);
      expect_obs(24'h00_00C0, 24'h00_0000);
    end
    PROFILE_LOWER <= 1'b1;
    PROFILE_CHANGE <= 1'b1;
    @(posedge SYS_CLK);
    PROFILE_CHANGE <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    expect_obs(24'h00_0202, 24'h00_0202);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
